// ---- tdf_pkg.sv ----
//==========================================================================
// Purpose: Constants and types for the transmit descriptor filter and
//          status block.
// Assumes: Descriptor words arrive whole from the descriptor fetch logic.
// Notes:   Register offsets are byte addresses on the plain register port.
//==========================================================================
// Operation
// - The filter type code is control word bit 28 (high) and bit 22 (low).
// - Control word bit 27 marks a setup descriptor instead of a frame.
// - The filter type code counts only on a setup descriptor.
// - Code 00 loads 16 exact addresses and selects perfect filtering.
// - Code 01 loads a 512-bit hash table plus one exact station address.
// - Under code 01 multicast is hashed and physical is matched exactly.
// - Code 10 loads 16 exact addresses and selects inverse filtering.
// - Inverse filtering keeps frames that match no stored address.
// - Code 11 loads only a 512-bit hash table and hashes every address.
// - Word 2 is the whole 32-bit buffer 1 address, any alignment.
// - Word 3 is the whole 32-bit buffer 2 address, any alignment.
// - Underflow makes all status valid; excess collisions all but count.
// - Jabber and loopback completions mark their own fields invalid.
package tdf_pkg;
    // Descriptor bit positions
    localparam int unsigned TDF_FILTER_TYPE_HIGH_BIT = 28;
    localparam int unsigned TDF_FILTER_TYPE_LOW_BIT  = 22;
    localparam int unsigned TDF_SETUP_BIT            = 27;

    // Register byte offsets
    localparam logic [7:0] TDF_OFS_CTRL   = 8'h00;
    localparam logic [7:0] TDF_OFS_MODE   = 8'h04;
    localparam logic [7:0] TDF_OFS_BUF1   = 8'h08;
    localparam logic [7:0] TDF_OFS_BUF2   = 8'h0C;
    localparam logic [7:0] TDF_OFS_VALID  = 8'h10;
    localparam logic [7:0] TDF_OFS_STATUS = 8'h14;
    localparam logic [7:0] TDF_OFS_IRQ_ST = 8'h18;
    localparam logic [7:0] TDF_OFS_IRQ_MK = 8'h1C;

    // Status field validity masks over the low half of status word 0
    localparam logic [15:0] TDF_VM_ALL      = 16'hCFFB;
    localparam logic [15:0] TDF_VM_EXCESS   = 16'hCF83;
    localparam logic [15:0] TDF_VM_JABBER   = 16'hC47B;
    localparam logic [15:0] TDF_VM_LOOPBACK = 16'hC37B;

    // Reset values
    localparam logic       TDF_CTRL_RST = 1'b1;
    localparam logic [3:0] TDF_MASK_RST = 4'h0;
    localparam logic       TDF_TBL_PERFECT_RST = 1'b1;

    typedef enum logic [1:0] {
        TDF_FM_PERFECT   = 2'b00,
        TDF_FM_HASH      = 2'b01,
        TDF_FM_INVERSE   = 2'b10,
        TDF_FM_HASH_ONLY = 2'b11
    } tdf_fmode_t;

    typedef enum logic [2:0] {
        TDF_OUT_NORMAL    = 3'b000,
        TDF_OUT_UNDERFLOW = 3'b001,
        TDF_OUT_EXCESS    = 3'b010,
        TDF_OUT_JABBER    = 3'b011,
        TDF_OUT_LOOPBACK  = 3'b100
    } tdf_outcome_t;

    // Descriptor words 1..3 from the fetch logic
    typedef struct packed {
        logic [31:0] tx_desc_word1_control;
        logic [31:0] tx_desc_word2_buf1_addr;
        logic [31:0] tx_desc_word3_buf2_addr;
    } tdf_desc_t;

    // Whole block state
    typedef struct packed {
        logic        enable;
        logic        pend;
        tdf_fmode_t  pend_mode;
        tdf_fmode_t  mode;
        logic        tbl_perfect;
        logic        hash_exact;
        logic        inverse;
        logic        hash_only;
        logic [31:0] buf1;
        logic [31:0] buf2;
        logic [15:0] vmask;
        logic [15:0] stat;
        logic [3:0]  irq_st;
        logic [3:0]  irq_mask;
        logic        irq;
        logic [31:0] rdata;
    } tdf_state_t;
endpackage : tdf_pkg

// ---- tdf_filter_status.sv ----
//==========================================================================
// Purpose: Decodes setup descriptors into the receive filter mode, takes
//          buffer addresses and marks which completion fields are valid.
// Assumes: All inputs come from logic on core_clk_in.
// Notes:   Interrupt events: 0 mode applied, 1 setup load failed,
//          2 completion reported, 3 type code ignored on frame descriptor.
//==========================================================================
`timescale 1ns/1ns
module tdf_filter_status (
    // Clock and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 nrst_in,
    // Descriptor fetch
    input  wire logic                 desc_valid_in,
    input  wire tdf_pkg::tdf_desc_t   desc_in,
    // Setup buffer load result
    input  wire logic                 setup_done_in,
    input  wire logic                 setup_ok_in,
    // Transmit completion
    input  wire logic                 done_valid_in,
    input  wire tdf_pkg::tdf_outcome_t done_kind_in,
    input  wire logic [31:0]          tx_desc_word0_status_in,
    // Register port
    input  wire logic [7:0]           reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic [31:0]               reg_rdata_out,
    // Filter control to receive side
    output logic [1:0]                filter_mode_out,
    output logic                      table_perfect_out,
    output logic                      hash_exact_phys_out,
    output logic                      inverse_out,
    output logic                      hash_only_out,
    // Buffer addresses
    output logic [31:0]               buf1_addr_out,
    output logic [31:0]               buf2_addr_out,
    // Completion report
    output logic [15:0]               status_valid_out,
    output logic                      irq_out
);

    //======================================================================
    // State
    //======================================================================
    tdf_pkg::tdf_state_t st_reg;
    tdf_pkg::tdf_state_t st_next;
    logic [31:0]         w1;
    logic                is_setup;
    tdf_pkg::tdf_fmode_t code;
    logic [3:0]          ev;
    logic                take_setup;

    assign w1       = desc_in.tx_desc_word1_control;
    assign is_setup = w1[tdf_pkg::TDF_SETUP_BIT];
    assign code     = tdf_pkg::tdf_fmode_t'({w1[tdf_pkg::TDF_FILTER_TYPE_HIGH_BIT],
                                            w1[tdf_pkg::TDF_FILTER_TYPE_LOW_BIT]});
    // Setup descriptor that will be held pending, shared with the checks below
    assign take_setup = is_setup && st_reg.enable && desc_valid_in;

    // Validity of status fields per completion kind
    function automatic logic [15:0] valid_mask(input tdf_pkg::tdf_outcome_t k);
        logic [15:0] m;
        m = tdf_pkg::TDF_VM_ALL;
        case (k)
            tdf_pkg::TDF_OUT_UNDERFLOW: m = tdf_pkg::TDF_VM_ALL;
            tdf_pkg::TDF_OUT_EXCESS:    m = tdf_pkg::TDF_VM_EXCESS;
            tdf_pkg::TDF_OUT_JABBER:    m = tdf_pkg::TDF_VM_JABBER;
            tdf_pkg::TDF_OUT_LOOPBACK:  m = tdf_pkg::TDF_VM_LOOPBACK;
            default:                    m = tdf_pkg::TDF_VM_ALL;
        endcase
        return m;
    endfunction : valid_mask

    //======================================================================
    // Next state
    //======================================================================
    // Set wins over read-clear, so an event in the read cycle survives
    always_comb
    begin
        st_next = st_reg;
        ev      = 4'h0;
        // Buffer addresses are taken whole, alignment is not checked
        if (desc_valid_in)
        begin
            st_next.buf1 = desc_in.tx_desc_word2_buf1_addr;
            st_next.buf2 = desc_in.tx_desc_word3_buf2_addr;
            if (is_setup && st_reg.enable)
            begin
                st_next.pend      = 1'b1;
                st_next.pend_mode = code;
            end
            else if (!is_setup && code != tdf_pkg::TDF_FM_PERFECT)
            begin
                ev[3] = 1'b1;
            end
        end
        // Mode switches only after the whole table is in, never mid-load
        if (setup_done_in && st_reg.pend)
        begin
            // A setup descriptor in the closing cycle stays pending, not lost
            st_next.pend = take_setup;
            if (setup_ok_in)
            begin
                st_next.mode        = st_reg.pend_mode;
                st_next.tbl_perfect = st_reg.pend_mode == tdf_pkg::TDF_FM_PERFECT ||
                                      st_reg.pend_mode == tdf_pkg::TDF_FM_INVERSE;
                st_next.hash_exact  = st_reg.pend_mode == tdf_pkg::TDF_FM_HASH;
                st_next.inverse     = st_reg.pend_mode == tdf_pkg::TDF_FM_INVERSE;
                st_next.hash_only   = st_reg.pend_mode == tdf_pkg::TDF_FM_HASH_ONLY;
                ev[0]               = 1'b1;
            end
            else
            begin
                ev[1] = 1'b1;
            end
        end
        // Completion status and its validity
        if (done_valid_in)
        begin
            st_next.vmask = valid_mask(done_kind_in);
            st_next.stat  = tx_desc_word0_status_in[15:0] & valid_mask(done_kind_in);
            ev[2]         = 1'b1;
        end
        // Register writes
        if (reg_wr_in)
        begin
            if (reg_addr_in == tdf_pkg::TDF_OFS_CTRL)
                st_next.enable = reg_wdata_in[0];
            else if (reg_addr_in == tdf_pkg::TDF_OFS_IRQ_MK)
                st_next.irq_mask = reg_wdata_in[3:0];
        end
        // Register reads, data stands for one cycle only
        st_next.rdata = 32'h0000_0000;
        if (reg_rd_in)
        begin
            if (reg_addr_in == tdf_pkg::TDF_OFS_CTRL)
                st_next.rdata = {31'h0, st_reg.enable};
            else if (reg_addr_in == tdf_pkg::TDF_OFS_MODE)
                st_next.rdata = {27'h0, st_reg.pend, st_reg.pend_mode, st_reg.mode};
            else if (reg_addr_in == tdf_pkg::TDF_OFS_BUF1)
                st_next.rdata = st_reg.buf1;
            else if (reg_addr_in == tdf_pkg::TDF_OFS_BUF2)
                st_next.rdata = st_reg.buf2;
            else if (reg_addr_in == tdf_pkg::TDF_OFS_VALID)
                st_next.rdata = {16'h0, st_reg.vmask};
            else if (reg_addr_in == tdf_pkg::TDF_OFS_STATUS)
                st_next.rdata = {16'h0, st_reg.stat};
            else if (reg_addr_in == tdf_pkg::TDF_OFS_IRQ_ST)
            begin
                st_next.rdata  = {28'h0, st_reg.irq_st};
                st_next.irq_st = 4'h0;
            end
            else if (reg_addr_in == tdf_pkg::TDF_OFS_IRQ_MK)
                st_next.rdata = {28'h0, st_reg.irq_mask};
        end
        st_next.irq_st = st_next.irq_st | ev;
        st_next.irq    = |(st_next.irq_st & st_next.irq_mask);
    end

    //======================================================================
    // State register
    //======================================================================
    always_ff @(posedge core_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_reg             <= '0;
            st_reg.enable      <= tdf_pkg::TDF_CTRL_RST;
            st_reg.irq_mask    <= tdf_pkg::TDF_MASK_RST;
            st_reg.tbl_perfect <= tdf_pkg::TDF_TBL_PERFECT_RST;
        end
        else
            st_reg <= st_next;
    end

    // Outputs straight from state flops
    assign reg_rdata_out       = st_reg.rdata;
    assign filter_mode_out     = st_reg.mode;
    assign table_perfect_out   = st_reg.tbl_perfect;
    assign hash_exact_phys_out = st_reg.hash_exact;
    assign inverse_out         = st_reg.inverse;
    assign hash_only_out       = st_reg.hash_only;
    assign buf1_addr_out       = st_reg.buf1;
    assign buf2_addr_out       = st_reg.buf2;
    assign status_valid_out    = st_reg.vmask;
    assign irq_out             = st_reg.irq;

    //======================================================================
    // Assertions
    //======================================================================
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_setup_desc;
        desc_valid_in && is_setup && st_reg.enable;
    endsequence

    sequence s_good_load;
        setup_done_in && setup_ok_in && st_reg.pend;
    endsequence

    sequence s_bad_load;
        setup_done_in && !setup_ok_in && st_reg.pend;
    endsequence

    sequence s_frame_code;
        desc_valid_in && !is_setup && code != tdf_pkg::TDF_FM_PERFECT;
    endsequence

    a_setup_code_take: assert property (s_setup_desc |=> st_reg.pend &&
        st_reg.pend_mode == $past(code))
        else $error("setup code not captured");

    a_frame_code_ignored: assert property (desc_valid_in && !is_setup &&
        !setup_done_in |=> $stable(st_reg.pend_mode) && $stable(st_reg.mode))
        else $error("frame descriptor changed filter code");

    a_mode_after_load: assert property (s_good_load |=>
        filter_mode_out == $past(st_reg.pend_mode) &&
        st_reg.pend == $past(take_setup))
        else $error("mode not applied after load");

    a_mode_held_midload: assert property (st_reg.pend && !setup_done_in |=>
        $stable(filter_mode_out))
        else $error("mode changed before load end");

    a_perfect_mode: assert property (s_good_load ##1 filter_mode_out == 2'b00 |->
        table_perfect_out && !inverse_out && !hash_only_out && !hash_exact_phys_out)
        else $error("perfect mode outputs wrong");

    a_hash_exact: assert property (s_good_load ##1 filter_mode_out == 2'b01 |->
        hash_exact_phys_out && !table_perfect_out && !hash_only_out)
        else $error("hash mode outputs wrong");

    a_inverse_mode: assert property (s_good_load ##1 filter_mode_out == 2'b10 |->
        inverse_out && table_perfect_out && !hash_only_out)
        else $error("inverse mode outputs wrong");

    a_hash_only: assert property (s_good_load ##1 filter_mode_out == 2'b11 |->
        hash_only_out && !table_perfect_out && !inverse_out)
        else $error("hash-only mode outputs wrong");

    a_buf_addrs: assert property (desc_valid_in |=>
        buf1_addr_out == $past(desc_in.tx_desc_word2_buf1_addr) &&
        buf2_addr_out == $past(desc_in.tx_desc_word3_buf2_addr))
        else $error("buffer address not taken");

    a_valid_underflow: assert property (done_valid_in &&
        done_kind_in == tdf_pkg::TDF_OUT_UNDERFLOW |=> status_valid_out == 16'hCFFB)
        else $error("underflow validity wrong");

    a_valid_excess: assert property (done_valid_in &&
        done_kind_in == tdf_pkg::TDF_OUT_EXCESS |=> status_valid_out[6:3] == 4'h0 &&
        status_valid_out[11:7] == 5'h1F)
        else $error("excess collision validity wrong");

    a_valid_jabber: assert property (done_valid_in &&
        done_kind_in == tdf_pkg::TDF_OUT_JABBER |=> status_valid_out == 16'hC47B)
        else $error("jabber validity wrong");

    a_valid_loopback: assert property (done_valid_in &&
        done_kind_in == tdf_pkg::TDF_OUT_LOOPBACK |=> status_valid_out == 16'hC37B)
        else $error("loopback validity wrong");

    a_read_one_cycle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data outside read slot");

    // A failed load must leave the receive filter exactly as it was
    a_bad_load_keeps: assert property (s_bad_load |=>
        $stable(filter_mode_out) && $stable(table_perfect_out) && st_reg.irq_st[1])
        else $error("failed load changed the filter mode");

    a_frame_code_event: assert property (s_frame_code |=> st_reg.irq_st[3])
        else $error("ignored frame code not reported");

    a_setup_disabled: assert property (desc_valid_in && is_setup &&
        !st_reg.enable && !st_reg.pend |=> !st_reg.pend)
        else $error("setup taken while decode disabled");

    // Mode flags must stay consistent with each other at all times
    a_inverse_table: assert property (inverse_out |->
        table_perfect_out && !hash_exact_phys_out && !hash_only_out)
        else $error("inverse mode without exact table");

    a_hash_table: assert property (hash_exact_phys_out |->
        !table_perfect_out && !inverse_out && filter_mode_out == 2'b01)
        else $error("hash mode flags inconsistent");

    // Fields marked invalid never reach the host as set bits
    a_stat_masked: assert property (done_valid_in |=>
        (st_reg.stat & ~status_valid_out) == 16'h0000)
        else $error("invalid status field reported");

    // Buffer addresses stand until the next descriptor
    a_buf_hold: assert property (!desc_valid_in |=>
        $stable(buf1_addr_out) && $stable(buf2_addr_out))
        else $error("buffer address moved without descriptor");

    // Set wins over the read-clear of the sticky bits
    a_irq_event_kept: assert property (done_valid_in |=> st_reg.irq_st[2])
        else $error("completion event lost");

    a_irq_read_clear: assert property (reg_rd_in && reg_addr_in == tdf_pkg::TDF_OFS_IRQ_ST &&
        !desc_valid_in && !setup_done_in && !done_valid_in |=> st_reg.irq_st == 4'h0)
        else $error("interrupt status not cleared by read");

    a_mode_read: assert property (reg_rd_in && reg_addr_in == tdf_pkg::TDF_OFS_MODE |=>
        reg_rdata_out[1:0] == $past(filter_mode_out))
        else $error("mode register read wrong");

endmodule : tdf_filter_status

// ---- tdf_host_model.sv ----
//==========================================================================
// Purpose: Host software side that builds transmit descriptor words.
// Assumes: Unrelated control bits carry arbitrary values.
// Notes:   Behavioural packing only; the bench sequences the fetch pulse.
//==========================================================================
`timescale 1ns/1ns
module tdf_host_model (
    // Descriptor fields
    input  wire logic          setup_in,
    input  wire logic [1:0]    code_in,
    input  wire logic [31:0]   noise_in,
    input  wire logic [31:0]   buf1_in,
    input  wire logic [31:0]   buf2_in,
    // Packed descriptor
    output tdf_pkg::tdf_desc_t desc_out
);
    // Noise fills every other control bit so the block must pick fields out
    always_comb
    begin
        desc_out = {noise_in, buf1_in, buf2_in};
        desc_out.tx_desc_word1_control[28] = code_in[1];
        desc_out.tx_desc_word1_control[22] = code_in[0];
        desc_out.tx_desc_word1_control[27] = setup_in;
    end
endmodule : tdf_host_model

// ---- tdf_filter_status_tb.sv ----
//==========================================================================
// Purpose: Self-checking bench for the descriptor filter and status block.
// Assumes: Host model packs descriptors; integer model tracks mode and events.
// Notes:   Validity masks are rebuilt here from the status field positions.
//==========================================================================
`timescale 1ns/1ns
module tdf_filter_status_tb;
    // Stimulus and observed signals
    logic        core_clk_in, nrst_in, desc_valid_in, setup_done_in, setup_ok_in;
    logic        done_valid_in, reg_wr_in, reg_rd_in, h_setup, tp, he, inv, ho, irq;
    logic [1:0]  h_code, fm;
    logic [7:0]  reg_addr_in;
    logic [15:0] sv;
    logic [31:0] h_noise, h_b1, h_b2, st_word, reg_wdata_in, rdata, b1o, b2o;
    tdf_pkg::tdf_outcome_t done_kind_in;
    tdf_pkg::tdf_desc_t    desc_w;
    // Reference model; a pend of -1 means no setup waiting
    int          fails, n_tests, m_mode, m_pend, m_ist, m_mask, m_en;

    tdf_host_model host (.setup_in(h_setup), .code_in(h_code), .noise_in(h_noise),
                         .buf1_in(h_b1), .buf2_in(h_b2), .desc_out(desc_w));
    tdf_filter_status DUT (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .desc_valid_in(desc_valid_in), .desc_in(desc_w), .setup_done_in(setup_done_in),
        .setup_ok_in(setup_ok_in), .done_valid_in(done_valid_in),
        .done_kind_in(done_kind_in), .tx_desc_word0_status_in(st_word),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(rdata), .filter_mode_out(fm),
        .table_perfect_out(tp), .hash_exact_phys_out(he), .inverse_out(inv),
        .hash_only_out(ho), .buf1_addr_out(b1o), .buf2_addr_out(b2o),
        .status_valid_out(sv), .irq_out(irq));

    //======================================================================
    // Helpers
    //======================================================================
    // Valid fields per outcome, built from the status bit positions
    function automatic logic [15:0] vm(input int k);
        logic [15:0] m;
        m = 16'hC003 | 16'h0F80 | 16'h0078;
        if (k == 2) m = m & ~16'h0078;
        if (k == 3) m = m & ~16'h0B80;
        if (k == 4) m = m & ~16'h0C80;
        return m;
    endfunction : vm

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // Register cycles: one-cycle strobes, read data checked the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rd

    task automatic chk_mode();
        chk(fm, m_mode[1:0]);
        chk({tp, he, inv, ho},
            {m_mode == 0 || m_mode == 2, m_mode == 1, m_mode == 2, m_mode == 3});
    endtask : chk_mode

    // Descriptor with random addresses and control noise
    task automatic send_desc(input logic s, input logic [1:0] c);
        @(posedge core_clk_in);
        h_setup       <= s;
        h_code        <= c;
        h_noise       <= $urandom;
        h_b1          <= $urandom;
        h_b2          <= $urandom;
        desc_valid_in <= 1'b1;
        @(posedge core_clk_in);
        desc_valid_in <= 1'b0;
        if (s && m_en) m_pend = c;
        if (!s && c != 0) m_ist = m_ist | 8;
        #1 chk(b1o, h_b1);
        chk(b2o, h_b2);
    endtask : send_desc

    task automatic load(input logic ok);
        @(posedge core_clk_in);
        setup_done_in <= 1'b1;
        setup_ok_in   <= ok;
        @(posedge core_clk_in);
        setup_done_in <= 1'b0;
        if (m_pend >= 0)
        begin
            if (ok) m_mode = m_pend;
            m_ist  = m_ist | (ok ? 1 : 2);
            m_pend = -1;
        end
        #1 chk_mode();
    endtask : load

    task automatic complete(input int k);
        @(posedge core_clk_in);
        done_valid_in <= 1'b1;
        done_kind_in  <= tdf_pkg::tdf_outcome_t'(k);
        st_word       <= $urandom;
        @(posedge core_clk_in);
        done_valid_in <= 1'b0;
        m_ist = m_ist | 4;
        #1 chk(sv, vm(k));
        rd(tdf_pkg::TDF_OFS_STATUS, {16'h0000, st_word[15:0] & vm(k)});
    endtask : complete

    // Level output first, then the read that clears the sticky bits
    task automatic rd_irq();
        @(posedge core_clk_in);
        #1 chk(irq, (m_ist & m_mask) != 0);
        rd(tdf_pkg::TDF_OFS_IRQ_ST, m_ist);
        m_ist = 0;
    endtask : rd_irq

    //======================================================================
    // Clock, watchdog and sequence
    //======================================================================
    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // Whole run needs about 140 cycles
    initial
    begin
        repeat (5000) @(posedge core_clk_in);
        fails++;
        test_done();
    end

    initial
    begin
        {nrst_in, desc_valid_in, setup_done_in, setup_ok_in, done_valid_in} = '0;
        {reg_wr_in, reg_rd_in, h_setup, h_code, reg_addr_in} = '0;
        {h_noise, h_b1, h_b2, st_word, reg_wdata_in} = '0;
        done_kind_in = tdf_pkg::TDF_OUT_NORMAL;
        {fails, n_tests, m_mode, m_ist, m_mask} = '0;
        m_pend = -1;
        m_en   = 1;
        void'($urandom(28));
        repeat (12) @(posedge core_clk_in);
        nrst_in <= 1'b1;
        #1 chk_mode();
        rd(tdf_pkg::TDF_OFS_CTRL, 32'h1);
        rd(tdf_pkg::TDF_OFS_IRQ_MK, 32'h0);
        rd(8'h40, 32'h0);
        wr(tdf_pkg::TDF_OFS_IRQ_MK, 32'hF);
        m_mask = 15;
        for (int c = 0; c < 4; c++)
        begin
            send_desc(1'b1, 2'(c));
            rd(tdf_pkg::TDF_OFS_MODE, 32'(16 + c * 4 + m_mode));
            load(1'b1);
            rd_irq();
            rd_irq();
        end
        send_desc(1'b0, 2'b01);
        load(1'b1);
        rd_irq();
        wr(tdf_pkg::TDF_OFS_BUF1, ~h_b1);
        rd(tdf_pkg::TDF_OFS_BUF1, h_b1);
        rd(tdf_pkg::TDF_OFS_BUF2, h_b2);
        for (int k = 0; k < 5; k++)
        begin
            complete(k);
            rd_irq();
        end
        wr(tdf_pkg::TDF_OFS_IRQ_MK, 32'h0);
        m_mask = 0;
        complete(3);
        rd_irq();
        wr(tdf_pkg::TDF_OFS_CTRL, 32'h0);
        m_en = 0;
        rd(tdf_pkg::TDF_OFS_CTRL, 32'h0);
        send_desc(1'b1, 2'b00);
        load(1'b1);
        wr(tdf_pkg::TDF_OFS_CTRL, 32'h1);
        m_en = 1;
        send_desc(1'b1, 2'b00);
        load(1'b0);
        rd_irq();
        test_done();
    end
endmodule : tdf_filter_status_tb
